// File: lcdcd_pkg.sv
// Purpose: constants and carrier types for the lcd command decoder
// Assumes: single 125 MHz clock domain
// Notes:   command codes, field positions and reset values live here
package lcdcd_pkg;

  localparam logic [7:0] CMD_DISP_OFF   = 8'hAE;
  localparam logic [7:0] CMD_DISP_ON    = 8'hAF;
  localparam logic [7:0] CMD_SEG_NORM   = 8'hA0;
  localparam logic [7:0] CMD_SEG_REV    = 8'hA1;
  localparam logic [7:0] CMD_BIAS_LO    = 8'hA2;
  localparam logic [7:0] CMD_BIAS_HI    = 8'hA3;
  localparam logic [7:0] CMD_ALL_OFF    = 8'hA4;
  localparam logic [7:0] CMD_ALL_ON     = 8'hA5;
  localparam logic [7:0] CMD_INV_OFF    = 8'hA6;
  localparam logic [7:0] CMD_INV_ON     = 8'hA7;
  localparam logic [7:0] CMD_RMW        = 8'hE0;
  localparam logic [7:0] CMD_RMW_END    = 8'hEE;
  localparam logic [7:0] CMD_RESET      = 8'hE2;
  localparam logic [1:0] START_TOP      = 2'h1;
  localparam logic [3:0] PAGE_TOP       = 4'hB;
  localparam logic [3:0] COL_HI_TOP     = 4'h1;
  localparam logic [3:0] COL_LO_TOP     = 4'h0;

  localparam logic [3:0] PAGE_MAX       = 4'h8;
  localparam logic [7:0] COL_LAST       = 8'h83;
  localparam logic [3:0] COL_HI_MAX     = 4'h8;
  localparam int         NUM_PAGES      = 9;
  localparam int         NUM_COLS       = 132;

  localparam int         STAT_BUSY      = 7;
  localparam int         STAT_SEG       = 6;
  localparam int         STAT_OFF       = 5;
  localparam int         STAT_RST       = 4;

  // init busy time; software reset holds busy this long
  localparam int         INIT_NS        = 64;
  localparam int         CLK_NS         = 8;
  localparam int         INIT_CYC       = (INIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] INIT_CNT       = 4'(INIT_CYC);

  typedef struct packed {
    logic       disp_on;
    logic       seg_rev;
    logic       inverse;
    logic       all_on;
    logic       bias_hi;
    logic       power_save;
    logic [5:0] start_line;
    logic       rmw;
  } lcdcd_mode_t;

  localparam lcdcd_mode_t MODE_RST = '{default: 1'b0};

  typedef struct packed {
    logic       cmd_data_select;
    logic       wr;
    logic       rd;
    logic       serial_sel;
    logic [7:0] data;
  } lcdcd_req_t;

endpackage : lcdcd_pkg

// File: lcdcd_decoder.sv
// Purpose: command/data decoder with display ram for a 132x65 stn panel driver
// Assumes: host strobes are one-cycle pulses synchronous to clk
// Notes:   scan-out side reads pixels through the pix_* port
//
// Summary of operation
// - AFh turns display on, AEh off
// - display off during all-on enters power save
// - 40h-7Fh sets six-bit display start line
// - B0h-B8h loads page; page 8 keeps bit 0
// - page change never alters shown image
// - column set from high and low nibble commands
// - column increments per access, stops at 131
// - status: busy, segment, off, reset; low zero
// - commands rejected while busy
// - segment bit low when mapping reversed
// - off bit high while display off
// - reset bit high during initialisation
// - data write stores byte, advances column
// - data read returns ram, dummy read first
// - no data read over serial link
// - A0h/A1h choose segment mapping
// - A6h/A7h choose normal or inverted pixels
// - A5h lights all, overrides inversion; A4h clears
// - all-on while display off enters power save
// - A2h/A3h select bias ratio set
// - E0h saves column, reads stop incrementing
// - other commands still run during rmw
// - end command restores saved column, exits rmw
`timescale 1ns/1ns

module lcdcd_decoder (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              hw_init_pin_n,
  input  wire lcdcd_pkg::lcdcd_req_t req,
  input  wire logic [3:0]        pix_page,
  input  wire logic [7:0]        pix_col,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  output logic                   busy,
  output logic                   disp_on,
  output logic                   seg_rev,
  output logic                   inverse,
  output logic                   all_on,
  output logic                   bias_hi,
  output logic                   power_save,
  output logic [5:0]             start_line,
  output logic [7:0]             pix_data
);

  ////////////////////////////////////////////////////////////////////////////
  lcdcd_pkg::lcdcd_mode_t mode_r, mode_nxt;
  logic [3:0]  page_r;
  logic [7:0]  col_r;
  logic [7:0]  col_save_r;
  logic [3:0]  col_hi_r;
  logic [3:0]  busy_cnt_r;
  logic        init_r;
  logic        rd_fresh_r;
  logic [7:0]  ram_r [lcdcd_pkg::NUM_PAGES][lcdcd_pkg::NUM_COLS];

  wire logic [7:0] d         = req.data;
  wire logic       is_cmd    = ~req.cmd_data_select;
  wire logic       busy_now  = (busy_cnt_r != 4'h0);
  wire logic       cmd_wr    = is_cmd & req.wr & ~busy_now;
  wire logic       stat_rd   = is_cmd & req.rd & ~req.serial_sel;
  wire logic       dat_wr    = req.cmd_data_select & req.wr;
  wire logic       dat_rd    = req.cmd_data_select & req.rd & ~req.serial_sel;
  wire logic       ram_ok    = (page_r <= lcdcd_pkg::PAGE_MAX) &&
                               (col_r <= lcdcd_pkg::COL_LAST);
  wire logic       col_adv   = dat_wr | (dat_rd & ~mode_r.rmw & ~rd_fresh_r);
  wire logic       col_end   = (col_r >= lcdcd_pkg::COL_LAST);
  wire logic       is_start  = cmd_wr && (d[7:6] == lcdcd_pkg::START_TOP);
  wire logic       is_page   = cmd_wr && (d[7:4] == lcdcd_pkg::PAGE_TOP)
                               && (d[3:0] <= lcdcd_pkg::PAGE_MAX);
  wire logic       is_col_hi = cmd_wr && (d[7:4] == lcdcd_pkg::COL_HI_TOP)
                               && (d[3:0] <= lcdcd_pkg::COL_HI_MAX);
  wire logic       is_col_lo = cmd_wr && (d[7:4] == lcdcd_pkg::COL_LO_TOP);
  wire logic       is_rst    = cmd_wr && (d == lcdcd_pkg::CMD_RESET);
  wire logic       is_rmw    = cmd_wr && (d == lcdcd_pkg::CMD_RMW);
  wire logic       is_end    = cmd_wr && (d == lcdcd_pkg::CMD_RMW_END);
  // page 8 is the indicator row: only bit 0 is writable
  wire logic [7:0] wr_byte   = (page_r == lcdcd_pkg::PAGE_MAX) ? {7'h00, d[0]} : d;
  wire logic [7:0] status    = {busy_now, ~mode_r.seg_rev, ~mode_r.disp_on,
                                init_r, 4'h0};
  wire logic [7:0] col_set   = {col_hi_r, d[3:0]};

  ////////////////////////////////////////////////////////////////////////////
  // mode byte decode; each command only touches its own field, except E2h which clears rmw and start line
  always_comb begin
    mode_nxt = mode_r;
    if (cmd_wr) begin
      case (d)
        lcdcd_pkg::CMD_DISP_ON:  mode_nxt.disp_on = 1'b1;
        lcdcd_pkg::CMD_DISP_OFF: mode_nxt.disp_on = 1'b0;
        lcdcd_pkg::CMD_SEG_NORM: mode_nxt.seg_rev = 1'b0;
        lcdcd_pkg::CMD_SEG_REV:  mode_nxt.seg_rev = 1'b1;
        lcdcd_pkg::CMD_INV_OFF:  mode_nxt.inverse = 1'b0;
        lcdcd_pkg::CMD_INV_ON:   mode_nxt.inverse = 1'b1;
        lcdcd_pkg::CMD_ALL_OFF:  mode_nxt.all_on  = 1'b0;
        lcdcd_pkg::CMD_ALL_ON:   mode_nxt.all_on  = 1'b1;
        lcdcd_pkg::CMD_BIAS_LO:  mode_nxt.bias_hi = 1'b0;
        lcdcd_pkg::CMD_BIAS_HI:  mode_nxt.bias_hi = 1'b1;
        lcdcd_pkg::CMD_RMW:      mode_nxt.rmw     = 1'b1;
        lcdcd_pkg::CMD_RMW_END:  mode_nxt.rmw     = 1'b0;
        lcdcd_pkg::CMD_RESET:    begin
          mode_nxt.rmw        = 1'b0;
          mode_nxt.start_line = 6'h00;
        end
        default:                 mode_nxt = mode_r;
      endcase
      if (is_start) begin
        mode_nxt.start_line = d[5:0];
      end
    end
    // power save is entered while off and all-on together; leaving either exits
    mode_nxt.power_save = ~mode_nxt.disp_on & mode_nxt.all_on;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= lcdcd_pkg::MODE_RST;
    end else if (!hw_init_pin_n) begin
      mode_r <= lcdcd_pkg::MODE_RST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // init flag and busy count; pin reset holds both while low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_r <= lcdcd_pkg::INIT_CNT;
      init_r     <= 1'b1;
    end else if (!hw_init_pin_n) begin
      busy_cnt_r <= lcdcd_pkg::INIT_CNT;
      init_r     <= 1'b1;
    end else if (is_rst) begin
      busy_cnt_r <= lcdcd_pkg::INIT_CNT;
      init_r     <= 1'b1;
    end else if (busy_now) begin
      busy_cnt_r <= busy_cnt_r - 4'h1;
      init_r     <= (busy_cnt_r != 4'h1);
    end else begin
      init_r     <= 1'b0;
    end
  end

  // page and column addressing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      page_r     <= 4'h0;
      col_r      <= 8'h00;
      col_hi_r   <= 4'h0;
      col_save_r <= 8'h00;
    end else if (!hw_init_pin_n || is_rst) begin
      page_r     <= 4'h0;
      col_r      <= 8'h00;
      col_hi_r   <= 4'h0;
    end else begin
      if (is_page) begin
        page_r <= d[3:0];
      end
      if (is_col_hi) begin
        col_hi_r <= d[3:0];
        col_r    <= {d[3:0], col_r[3:0]};
      end else if (is_col_lo) begin
        col_r    <= col_set;
      end else if (is_rmw) begin
        col_save_r <= col_r;
      end else if (is_end && mode_r.rmw) begin
        col_r    <= col_save_r;
      end else if (col_adv && !col_end) begin
        col_r    <= col_r + 8'h01;
      end
    end
  end

  // first data read after a column set is the host's dummy read: it
  // returns the cell but holds the column, so no cell is skipped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_fresh_r <= 1'b0;
    end else if (!hw_init_pin_n || is_rst) begin
      rd_fresh_r <= 1'b0;
    end else if (is_col_hi || is_col_lo) begin
      rd_fresh_r <= 1'b1;
    end else if (dat_rd || dat_wr) begin
      rd_fresh_r <= 1'b0;
    end
  end

  // ram write; ram is never cleared by reset
  always_ff @(posedge clk) begin
    if (dat_wr && ram_ok && hw_init_pin_n) begin
      ram_r[page_r][col_r] <= wr_byte;
    end
  end

  // host read path: status or ram, data valid one cycle later.
  // dummy read after a column set returns the current cell, column held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= stat_rd | dat_rd;
      if (stat_rd) begin
        rd_data <= status;
      end else if (dat_rd) begin
        rd_data <= ram_ok ? ram_r[page_r][col_r] : 8'h00;
      end
    end
  end

  // scan-out: pixel byte with inversion and all-on applied
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pix_data <= 8'h00;
    end else if (!mode_r.disp_on) begin
      pix_data <= 8'h00;
    end else if (mode_r.all_on) begin
      pix_data <= 8'hFF;
    end else if (pix_page <= lcdcd_pkg::PAGE_MAX && pix_col <= lcdcd_pkg::COL_LAST) begin
      pix_data <= ram_r[pix_page][pix_col] ^ {8{mode_r.inverse}};
    end else begin
      pix_data <= 8'h00;
    end
  end

  // mode outputs from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy       <= 1'b1;
      disp_on    <= 1'b0;
      seg_rev    <= 1'b0;
      inverse    <= 1'b0;
      all_on     <= 1'b0;
      bias_hi    <= 1'b0;
      power_save <= 1'b0;
      start_line <= 6'h00;
    end else begin
      busy       <= busy_now;
      disp_on    <= mode_r.disp_on;
      seg_rev    <= mode_r.seg_rev;
      inverse    <= mode_r.inverse;
      all_on     <= mode_r.all_on;
      bias_hi    <= mode_r.bias_hi;
      power_save <= mode_r.power_save;
      start_line <= mode_r.start_line;
    end
  end

endmodule : lcdcd_decoder

// File: lcdcd_decoder_assertions.sv
// Purpose: port-level checker for the lcd command decoder
// Assumes: one clock, async active-high reset
// Notes:   command effects checked at the documented mode latency
`timescale 1ns/1ns

module lcdcd_decoder_chk (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire lcdcd_pkg::lcdcd_req_t req,
  input wire logic                  rd_valid,
  input wire logic                  busy,
  input wire logic                  disp_on,
  input wire logic                  seg_rev,
  input wire logic                  inverse,
  input wire logic                  all_on,
  input wire logic                  bias_hi,
  input wire logic                  power_save,
  input wire logic [5:0]            start_line
);
  wire logic       cw = req.wr && !req.cmd_data_select;
  wire logic [7:0] cd = req.data;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // busy output lags the accept decision by one cycle, hence ##1 !busy
  a_disp_on_cmd: assert property ((cw && cd == 8'hAF) ##1 !busy |-> ##2 disp_on)
    else $error("display on missed");
  a_disp_off_cmd: assert property ((cw && cd == 8'hAE) ##1 !busy |-> ##2 !disp_on)
    else $error("display off missed");
  a_busy_drop: assert property ((cw && cd == 8'hAE && disp_on) ##1 busy |-> ##2 disp_on)
    else $error("command taken while busy");
  a_seg_map: assert property ((cw && cd[7:1] == 7'h50) ##1 !busy |-> ##2 seg_rev == $past(cd[0], 3))
    else $error("segment mapping wrong");
  a_inv_sel: assert property ((cw && cd[7:1] == 7'h53) ##1 !busy |-> ##2 inverse == $past(cd[0], 3))
    else $error("inverse wrong");
  a_all_sel: assert property ((cw && cd[7:1] == 7'h52) ##1 !busy |-> ##2 all_on == $past(cd[0], 3))
    else $error("all on wrong");
  a_bias_sel: assert property ((cw && cd[7:1] == 7'h51) ##1 !busy |-> ##2 bias_hi == $past(cd[0], 3))
    else $error("bias wrong");
  a_start_set: assert property ((cw && cd[7:6] == 2'b01) ##1 !busy |-> ##2 start_line == $past(cd[5:0], 3))
    else $error("start line wrong");
  a_save_mode: assert property (power_save == (!disp_on && all_on))
    else $error("power save wrong");
  a_read_ans: assert property (req.rd && !req.serial_sel |=> rd_valid)
    else $error("read not answered");
  a_serial_rd: assert property (req.rd && req.serial_sel |=> !rd_valid)
    else $error("serial read answered");
  cover property (cw && cd == 8'hE0);
  cover property (req.rd && req.serial_sel);
  cover property (power_save);
endmodule : lcdcd_decoder_chk

bind lcdcd_decoder lcdcd_decoder_chk u_chk (.clk, .rst, .req, .rd_valid, .busy, .disp_on,
  .seg_rev, .inverse, .all_on, .bias_hi, .power_save, .start_line);

// File: lcdcd_host.sv
// Purpose: host model driving the command/data strobes
// Assumes: strobes are one-cycle pulses launched at the falling edge
// Notes:   serial bytes arrive already assembled
`timescale 1ns/1ns

module lcdcd_host (
  input  wire logic           clk,
  output lcdcd_pkg::lcdcd_req_t req
);
  initial req = '0;
  task automatic xfer(input logic cds, input logic rd, input logic ser, input logic [7:0] d);
    @(negedge clk);
    req <= '{cds, ~rd, rd, ser, d};
    @(negedge clk);
    // released bus shows the inverse so stale data cannot pass
    req <= '{1'b0, 1'b0, 1'b0, 1'b0, ~d};
  endtask : xfer
endmodule : lcdcd_host

// File: test_lcdcd_decoder.sv
// Purpose: self-checking bench for the lcd command decoder
// Assumes: reads noted in a queue, checked when rd_valid shows
// Notes:   dummy read returns current address data
`timescale 1ns/1ns

module test_lcdcd_decoder;
  logic                  clk = 0, rst = 1, hw_init_pin_n = 1;
  logic [3:0]            pix_page = 0;
  logic [7:0]            pix_col = 0, rd_data, pix_data, c, d0, d1, b;
  logic                  rd_valid, busy, disp_on, seg_rev, inverse, all_on, bias_hi, power_save;
  logic [5:0]            start_line;
  lcdcd_pkg::lcdcd_req_t req;
  int                    failures = 0, checked = 0;
  logic [7:0]            expq[$];
  logic [31:0]           seed = 34323;
  logic [7:0] mc [13] = '{8'hAF, 8'hA1, 8'hA7, 8'hA5, 8'hA3, 8'hAE, 8'hA4, 8'hA5, 8'hA4,
                          8'hA0, 8'hA6, 8'hA2, 8'hAF};
  logic [5:0] me [13] = '{6'h20, 6'h30, 6'h38, 6'h3C, 6'h3E, 6'h1F, 6'h1A, 6'h1F, 6'h1A,
                          6'h0A, 6'h02, 6'h00, 6'h20};
  always #4 clk = ~clk;
  lcdcd_decoder u_dut (.clk, .rst, .hw_init_pin_n, .req, .pix_page, .pix_col, .rd_data,
    .rd_valid, .busy, .disp_on, .seg_rev, .inverse, .all_on, .bias_hi, .power_save,
    .start_line, .pix_data);
  lcdcd_host u_host (.clk, .req);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic cmd(input logic [7:0] v);
    u_host.xfer(1'b0, 1'b0, 1'b0, v);
  endtask : cmd
  task automatic wd(input logic [7:0] v);
    u_host.xfer(1'b1, 1'b0, 1'b0, v);
  endtask : wd
  task automatic rd(input logic cds, input logic [7:0] e);
    expq.push_back(e);
    u_host.xfer(cds, 1'b1, 1'b0, 8'h00);
  endtask : rd
  task automatic col(input logic [7:0] v);
    cmd({4'h1, v[7:4]});
    cmd({4'h0, v[3:0]});
  endtask : col
  task automatic mode(input logic [5:0] e);
    cmp({2'b00, disp_on, seg_rev, inverse, all_on, bias_hi, power_save}, {2'b00, e});
  endtask : mode
  task automatic ready();
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
    idle(1);
  endtask : ready
  task automatic complete_run();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) if (rd_valid === 1'b1) cmp(rd_data, expq.size() ? expq.pop_front() : 8'hXX);
  initial begin
    #40000;
    failures++;
    $display("watchdog expired");
    complete_run();
  end
  initial begin
    idle(16);
    rst = 0;
    rd(1'b0, 8'hF0);
    ready();
    rd(1'b0, 8'h60);
    $display("test reset done");
    foreach (mc[i]) begin
      cmd(mc[i]);
      idle(2);
      mode(me[i]);
    end
    rd(1'b0, 8'h40);
    b = rnd();
    cmd({2'b01, b[5:0]});
    idle(2);
    cmp({2'b00, start_line}, {2'b00, b[5:0]});
    $display("test modes done");
    c = rnd();
    c[7] = 1'b0;
    d0 = rnd();
    d1 = rnd();
    cmd(8'hB2);
    col(c);
    wd(d0);
    wd(d1);
    pix_page = 4'h2;
    pix_col = c + 8'h01;
    idle(3);
    cmp(pix_data, d1);
    cmd(8'hB5);
    idle(3);
    cmp(pix_data, d1);
    cmd(8'hA7);
    idle(3);
    cmp(pix_data, ~d1);
    cmd(8'hA5);
    idle(3);
    cmp(pix_data, 8'hFF);
    cmd(8'hA4);
    cmd(8'hA6);
    cmd(8'hB2);
    col(c);
    rd(1'b1, d0);
    rd(1'b1, d0);
    rd(1'b1, d1);
    col(c);
    cmd(8'hE0);
    rd(1'b1, d0);
    rd(1'b1, d0);
    wd(~d0);
    cmd(8'hA1);
    rd(1'b0, 8'h00);
    rd(1'b1, d1);
    cmd(8'hEE);
    rd(1'b1, ~d0);
    cmd(8'hA0);
    u_host.xfer(1'b1, 1'b1, 1'b1, 8'h00);
    $display("test data done");
    col(8'h83);
    wd(8'hAA);
    wd(8'h55);
    col(8'h83);
    rd(1'b1, 8'h55);
    rd(1'b1, 8'h55);
    cmd(8'hB8);
    cmd(8'hB9);
    col(8'h00);
    wd(8'hFF);
    col(8'h00);
    rd(1'b1, 8'h01);
    rd(1'b1, 8'h01);
    cmd(8'hE2);
    cmd(8'hAE);
    ready();
    idle(2);
    mode(6'h20);
    cmp({2'b00, start_line}, 8'h00);
    hw_init_pin_n = 1'b0;
    idle(2);
    hw_init_pin_n = 1'b1;
    rd(1'b0, 8'hF0);
    ready();
    rd(1'b0, 8'h60);
    $display("test limits done");
    idle(4);
    complete_run();
  end
endmodule : test_lcdcd_decoder
